// File: include/csed_pkg.sv
// Purpose: shared constants for the charge state end detector
// Assumes: 40 MHz reference clock, millivolt and milliamp units
// Notes: every named constant the block uses lives here
package csed_pkg;
  // data path widths
  localparam int DATA_W = 32;
  localparam int OCV_ENTRIES = 101;
  localparam int OCV_IDX_W = 7;
  // percentage end points and hold values
  localparam logic signed [31:0] PCT_EMPTY = 32'sh0000_0000;
  localparam logic signed [31:0] PCT_LOW_HOLD = 32'sh0000_0001;
  localparam logic signed [31:0] PCT_HIGH_HOLD = 32'sh0000_0063;
  localparam logic signed [31:0] PCT_FULL = 32'sh0000_0064;
  // technique selector encoding
  localparam logic SEL_ACCUM = 1'b0;
  localparam logic SEL_ADAPT = 1'b1;
  // timing: qualification period counts microseconds
  localparam int CLK_PERIOD_PS = 25000;
  localparam int US_PS = 1000000;
  localparam int CYC_PER_US = US_PS / CLK_PERIOD_PS;
  localparam int PRE_W = 6;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);
  // reset values
  localparam logic [31:0] ZERO_32 = 32'h0000_0000;
  // full qualification states, gray coded along the usual path
  typedef enum logic [1:0] {
    QS_IDLE = 2'b00,
    QS_QUAL = 2'b01,
    QS_FULL = 2'b11
  } csed_qual_t;
endpackage : csed_pkg

// File: verilog/csed_top.sv
// Purpose: charge percentage end conditions, technique routing, OCV table
// Assumes: measurement inputs are synchronous; charge current is negative
// Notes: configuration arrives as plain ports, outputs come from flops
//
// Summary of operation
// - estimation runs only while enable is one
// - selector zero accumulated, one adaptive result
// - selected percentage and depth presented read-only
// - min-cell empty threshold, zero disables it
// - avg-cell empty threshold, zero disables it
// - unmet empty condition holds one percent
// - max-cell full threshold, zero disables it
// - avg-cell full threshold, zero disables it
// - full evaluated only while current is negative
// - full limit is signed negative, default huge
// - hold current positive, negated as upper bound
// - qualification period in microseconds, zero immediate
// - hundred percent needs voltage and current window
// - current stays in window whole period
// - unmet full condition holds ninety-nine percent
// - 101-entry OCV table, index zero empty
// - nominal capacity kept as reference
// - nominal cycle life, zero excludes cycles
`timescale 1ns/10ps
module csed_top (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic charge_estimation_on_in,
  input wire logic charge_technique_select_in,
  input wire logic [csed_pkg::DATA_W-1:0] nominal_capacity_cfg_in,
  input wire logic [csed_pkg::DATA_W-1:0] nominal_cycle_life_cfg_in,
  input wire logic [csed_pkg::DATA_W-1:0] empty_min_cell_voltage_in,
  input wire logic [csed_pkg::DATA_W-1:0] empty_avg_cell_voltage_in,
  input wire logic [csed_pkg::DATA_W-1:0] full_max_cell_voltage_in,
  input wire logic [csed_pkg::DATA_W-1:0] full_avg_cell_voltage_in,
  input wire logic signed [csed_pkg::DATA_W-1:0] full_current_limit_in,
  input wire logic [csed_pkg::DATA_W-1:0] taper_current_bound_in,
  input wire logic [csed_pkg::DATA_W-1:0] full_qualify_period_in,
  input wire logic [csed_pkg::DATA_W-1:0] min_cell_mv_in,
  input wire logic [csed_pkg::DATA_W-1:0] max_cell_mv_in,
  input wire logic [csed_pkg::DATA_W-1:0] avg_cell_mv_in,
  input wire logic signed [csed_pkg::DATA_W-1:0] stack_current_ma_in,
  input wire logic signed [csed_pkg::DATA_W-1:0] accum_pct_in,
  input wire logic [csed_pkg::DATA_W-1:0] accum_dod_in,
  input wire logic signed [csed_pkg::DATA_W-1:0] adapt_pct_in,
  input wire logic [csed_pkg::DATA_W-1:0] adapt_dod_in,
  input wire logic ocv_wr_en_in,
  input wire logic [csed_pkg::OCV_IDX_W-1:0] ocv_wr_idx_in,
  input wire logic [csed_pkg::DATA_W-1:0] ocv_wr_mv_in,
  input wire logic [csed_pkg::OCV_IDX_W-1:0] ocv_rd_idx_in,
  output logic [csed_pkg::DATA_W-1:0] ocv_rd_mv_out,
  output logic signed [csed_pkg::DATA_W-1:0] charge_percentage_out,
  output logic [csed_pkg::DATA_W-1:0] discharge_depth_out,
  output logic full_reached_out,
  output logic empty_reached_out,
  output logic [csed_pkg::DATA_W-1:0] nominal_capacity_out,
  output logic cycle_count_used_out
);
  import csed_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // end condition detection

  logic empty_min_hit;
  logic empty_avg_hit;
  logic empty_now;
  logic full_volt;
  logic in_window;
  logic signed [DATA_W-1:0] taper_neg;

  assign empty_min_hit = (empty_min_cell_voltage_in != ZERO_32) &&
                         (min_cell_mv_in <= empty_min_cell_voltage_in);
  assign empty_avg_hit = (empty_avg_cell_voltage_in != ZERO_32) &&
                         (avg_cell_mv_in <= empty_avg_cell_voltage_in);
  assign empty_now = empty_min_hit || empty_avg_hit;

  // max-cell full criterion; avg-cell criterion alongside
  assign full_volt = ((full_max_cell_voltage_in != ZERO_32) &&
                      (max_cell_mv_in >= full_max_cell_voltage_in)) ||
                     ((full_avg_cell_voltage_in != ZERO_32) &&
                      (avg_cell_mv_in >= full_avg_cell_voltage_in));

  // hold current negated as window top
  assign taper_neg = -$signed(taper_current_bound_in);
  // only charging current counts; limit is window bottom
  assign in_window = (stack_current_ma_in < 0) &&
                     (stack_current_ma_in >= full_current_limit_in) &&
                     (stack_current_ma_in <= taper_neg);

  ////////////////////////////////////////////////////////////////////////////
  // full qualification timer

  csed_qual_t qs_q;
  csed_qual_t qs_d;
  logic [PRE_W-1:0] pre_q;
  logic [DATA_W-1:0] us_q;
  logic qual_ok;

  // zero period qualifies at once, else counted microseconds
  assign qual_ok = (full_qualify_period_in == ZERO_32) ||
                   (us_q >= full_qualify_period_in);

  // next state; leaving the window drops straight back to idle
  always_comb begin
    qs_d = qs_q;
    case (qs_q)
      QS_IDLE: begin
        if (full_volt && in_window) begin
          qs_d = (full_qualify_period_in == ZERO_32) ? QS_FULL : QS_QUAL;
        end
      end
      QS_QUAL: begin
        // restart on window or voltage loss
        if (!(full_volt && in_window)) begin
          qs_d = QS_IDLE;
        end else if (qual_ok) begin
          qs_d = QS_FULL;
        end
      end
      QS_FULL: begin
        if (!(full_volt && in_window)) begin
          qs_d = QS_IDLE;
        end
      end
      default: begin
        qs_d = QS_IDLE;
      end
    endcase
  end

  // state register; disabled estimation keeps the timer parked
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      qs_q <= QS_IDLE;
    end else if (clk_en_in) begin
      qs_q <= charge_estimation_on_in ? qs_d : QS_IDLE;
    end
  end

  // microsecond count while continuously in window
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pre_q <= '0;
      us_q <= ZERO_32;
    end else if (clk_en_in) begin
      if (qs_q != QS_QUAL || qs_d != QS_QUAL) begin
        pre_q <= '0;
        us_q <= ZERO_32;
      end else if (pre_q == PRE_LAST) begin
        pre_q <= '0;
        // saturate so a long hold never wraps back under the period
        if (us_q != '1) begin
          us_q <= us_q + 32'h0000_0001;
        end
      end else begin
        pre_q <= pre_q + PRE_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // technique routing and percentage limiting

  logic signed [DATA_W-1:0] raw_pct;
  logic [DATA_W-1:0] raw_dod;
  logic signed [DATA_W-1:0] pct_d;

  assign raw_pct = (charge_technique_select_in == SEL_ADAPT) ?
                   adapt_pct_in : accum_pct_in;
  assign raw_dod = (charge_technique_select_in == SEL_ADAPT) ?
                   adapt_dod_in : accum_dod_in;

  // end points are only reachable through the detected conditions
  always_comb begin
    pct_d = raw_pct;
    if (qs_d == QS_FULL) begin
      // full needs voltage plus qualified current
      pct_d = PCT_FULL;
    end else if (empty_now) begin
      pct_d = PCT_EMPTY;
    end else if (raw_pct >= PCT_FULL) begin
      pct_d = PCT_HIGH_HOLD;
    end else if (raw_pct <= PCT_EMPTY) begin
      pct_d = PCT_LOW_HOLD;
    end
  end

  // outputs refresh only while estimation enabled
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      charge_percentage_out <= PCT_EMPTY;
      discharge_depth_out <= ZERO_32;
      full_reached_out <= 1'b0;
      empty_reached_out <= 1'b0;
    end else if (clk_en_in && charge_estimation_on_in) begin
      charge_percentage_out <= pct_d;
      discharge_depth_out <= raw_dod;
      full_reached_out <= (qs_d == QS_FULL);
      empty_reached_out <= empty_now && (qs_d != QS_FULL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capacity and cycle life references

  // capacity reference; cycle life zero excludes
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      nominal_capacity_out <= ZERO_32;
      cycle_count_used_out <= 1'b0;
    end else if (clk_en_in) begin
      nominal_capacity_out <= nominal_capacity_cfg_in;
      cycle_count_used_out <= (nominal_cycle_life_cfg_in != ZERO_32);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open circuit voltage table

  logic [DATA_W-1:0] ocv_mem [OCV_ENTRIES];

  // one entry per percent; out-of-range writes dropped
  always_ff @(posedge ref_clk_in) begin
    if (clk_en_in && ocv_wr_en_in &&
        (ocv_wr_idx_in < OCV_IDX_W'(OCV_ENTRIES))) begin
      ocv_mem[ocv_wr_idx_in] <= ocv_wr_mv_in;
    end
  end

  // registered read; indices past the table read zero
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ocv_rd_mv_out <= ZERO_32;
    end else if (clk_en_in) begin
      if (ocv_rd_idx_in < OCV_IDX_W'(OCV_ENTRIES)) begin
        ocv_rd_mv_out <= ocv_mem[ocv_rd_idx_in];
      end else begin
        ocv_rd_mv_out <= ZERO_32;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_disabled_freeze: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !charge_estimation_on_in |=> $stable(charge_percentage_out))
    else $error("percentage moved while estimation disabled");

  a_dod_routing: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in) |=>
      discharge_depth_out == ($past(charge_technique_select_in) ?
                              $past(adapt_dod_in) : $past(accum_dod_in)))
    else $error("depth of discharge not from selected technique");

  a_empty_gives_zero: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in && empty_min_hit &&
     qs_d != QS_FULL) |=> charge_percentage_out == PCT_EMPTY)
    else $error("empty criterion did not give zero percent");

  a_low_hold_one: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in && !empty_now &&
     qs_d != QS_FULL && raw_pct <= PCT_EMPTY) |=>
      charge_percentage_out == PCT_LOW_HOLD)
    else $error("bottom not held at one percent");

  a_full_needs_charge: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in) ##1 full_reached_out |->
      $past(stack_current_ma_in) < 0)
    else $error("full declared without charging current");

  a_zero_period_fast: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in && qs_q == QS_IDLE &&
     full_volt && in_window && full_qualify_period_in == ZERO_32) |=>
      qs_q == QS_FULL)
    else $error("zero period did not qualify at once");

  a_full_gives_hundred: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    full_reached_out |-> charge_percentage_out == PCT_FULL)
    else $error("full flag without hundred percent");

  a_qual_waits_period: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (qs_q == QS_QUAL && qs_d == QS_FULL) |->
      us_q >= full_qualify_period_in)
    else $error("full reached before period elapsed");

  a_high_hold: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in && !empty_now &&
     qs_d != QS_FULL && raw_pct >= PCT_FULL) |=>
      charge_percentage_out == PCT_HIGH_HOLD)
    else $error("top not held at ninety-nine percent");

  a_timer_restart: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && !(full_volt && in_window)) |=> us_q == ZERO_32)
    else $error("qualification timer not restarted");

  a_pct_range: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    charge_percentage_out >= PCT_EMPTY && charge_percentage_out <= PCT_FULL)
    else $error("percentage outside zero to hundred");

  // in-range results pass through untouched from the chosen technique
  a_pct_routing: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in && qs_d != QS_FULL && !empty_now &&
     raw_pct > PCT_EMPTY && raw_pct < PCT_FULL) |=>
      charge_percentage_out == $past(raw_pct))
    else $error("percentage not from selected technique");

  a_depth_frozen: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !clk_en_in |=> $stable(discharge_depth_out))
    else $error("depth moved while clock enable low");

  a_avg_empty_flag: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in && empty_avg_hit &&
     qs_d != QS_FULL) |=> empty_reached_out)
    else $error("average empty criterion not flagged");

  a_max_full_volt: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in && qs_q == QS_IDLE &&
     full_max_cell_voltage_in != ZERO_32 &&
     max_cell_mv_in >= full_max_cell_voltage_in && in_window &&
     full_qualify_period_in == ZERO_32) |=> full_reached_out)
    else $error("max-cell full criterion ignored");

  a_avg_full_volt: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in && qs_q == QS_IDLE &&
     full_avg_cell_voltage_in != ZERO_32 &&
     avg_cell_mv_in >= full_avg_cell_voltage_in && in_window &&
     full_qualify_period_in == ZERO_32) |=> full_reached_out)
    else $error("avg-cell full criterion ignored");

  // a fresh full flag must come from a current inside the window
  a_window_bottom: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in) ##1 full_reached_out |->
      $past(stack_current_ma_in) >= $past(full_current_limit_in))
    else $error("full declared below current limit");

  a_window_top: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && charge_estimation_on_in) ##1 full_reached_out |->
      $past(stack_current_ma_in) <= $past(taper_neg))
    else $error("full declared above negated hold current");

  a_disabled_parks: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (clk_en_in && !charge_estimation_on_in) |=> qs_q == QS_IDLE)
    else $error("timer not parked while estimation disabled");

  a_capacity_copy: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    clk_en_in |=> nominal_capacity_out == $past(nominal_capacity_cfg_in))
    else $error("capacity reference not kept");

  a_cycle_use: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    clk_en_in |=> cycle_count_used_out ==
      ($past(nominal_cycle_life_cfg_in) != ZERO_32))
    else $error("cycle life use flag wrong");

endmodule : csed_top

// File: tb/csed_top_bench.sv
// Purpose: self-checking bench for the charge state end detector
// Assumes: 40 MHz clock, inputs driven 1 ns after the rising edge
// Notes: short qualification period keeps the full wait near 80 cycles
`timescale 1ns/10ps
module csed_top_bench;
  import csed_pkg::*;
  `define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); \
    end end
  logic clk = 1'b0, rst = 1'b1, en = 1'b1, est = 1'b0, sel = 1'b0;
  logic [31:0] cap = 32'h0000_0000, life = 32'h0000_0000;
  logic [31:0] e_min = 32'h0, e_avg = 32'h0, f_max = 32'h0, f_avg = 32'h0;
  logic signed [31:0] lim = 32'sh8000_0000, cur = 32'sh0;
  logic [31:0] taper = 32'h5, period = 32'h0;
  logic [31:0] min_mv = 32'hce4, max_mv = 32'hce4, avg_mv = 32'hce4;
  logic signed [31:0] a_pct = 32'sh0, d_pct = 32'sh0;
  logic [31:0] a_dod = 32'h0, d_dod = 32'h0, wr_mv = 32'h0, rd_mv, dod, cap_o;
  logic wr_en = 1'b0, full, empty, cyc_o;
  logic [6:0] wr_idx = 7'h00, rd_idx = 7'h00;
  logic signed [31:0] pct;
  int n_errors = 0, check_count = 0, k;
  ////////////////////////////////////////////////////////////////////////////
  // clock toggles every half period of 25 ns
  always #12.5 clk = ~clk;
  csed_top dut (.ref_clk_in(clk), .reset_in(rst), .clk_en_in(en),
    .charge_estimation_on_in(est), .charge_technique_select_in(sel),
    .nominal_capacity_cfg_in(cap), .nominal_cycle_life_cfg_in(life),
    .empty_min_cell_voltage_in(e_min), .empty_avg_cell_voltage_in(e_avg),
    .full_max_cell_voltage_in(f_max), .full_avg_cell_voltage_in(f_avg),
    .full_current_limit_in(lim), .taper_current_bound_in(taper),
    .full_qualify_period_in(period), .min_cell_mv_in(min_mv),
    .max_cell_mv_in(max_mv), .avg_cell_mv_in(avg_mv),
    .stack_current_ma_in(cur), .accum_pct_in(a_pct), .accum_dod_in(a_dod),
    .adapt_pct_in(d_pct), .adapt_dod_in(d_dod), .ocv_wr_en_in(wr_en),
    .ocv_wr_idx_in(wr_idx), .ocv_wr_mv_in(wr_mv), .ocv_rd_idx_in(rd_idx),
    .ocv_rd_mv_out(rd_mv), .charge_percentage_out(pct),
    .discharge_depth_out(dod), .full_reached_out(full),
    .empty_reached_out(empty), .nominal_capacity_out(cap_o),
    .cycle_count_used_out(cyc_o));
  ////////////////////////////////////////////////////////////////////////////
  // advance n edges, then move off the edge so inputs never race it
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // routing by selector, also the enable and clock-enable freezes
  task automatic t_route;
    est = 1'b1; a_pct = 32'sd50; a_dod = 32'h1234; d_pct = 32'sd70;
    d_dod = 32'h4321; sel = SEL_ACCUM; step(2);
    `CHK(pct, 32'sd50)
    `CHK(dod, 32'h1234)
    sel = SEL_ADAPT; step(2);
    `CHK(pct, 32'sd70)
    `CHK(dod, 32'h4321)
    est = 1'b0; d_pct = 32'sd20; step(3);
    `CHK(pct, 32'sd70)
    est = 1'b1; en = 1'b0; step(3);
    `CHK(pct, 32'sd70)
    en = 1'b1; step(2);
    `CHK(pct, 32'sd20)
    $display("test route done");
  endtask : t_route
  // raw results outside 1..99 are held unless an end condition is met
  task automatic t_clamp;
    d_pct = 32'sd120; step(2);
    `CHK(pct, PCT_HIGH_HOLD)
    d_pct = -32'sd3; step(2);
    `CHK(pct, PCT_LOW_HOLD)
    `CHK(empty, 1'b0)
    $display("test clamp done");
  endtask : t_clamp
  // empty thresholds inclusive, zero disables each one
  task automatic t_empty;
    d_pct = 32'sd5; e_min = 32'hbb8; min_mv = 32'hbb8; step(2);
    `CHK(pct, PCT_EMPTY)
    `CHK(empty, 1'b1)
    min_mv = 32'hbb9; step(2);
    `CHK(pct, 32'sd5)
    e_min = 32'h0; min_mv = 32'h7d0; e_avg = 32'hc1c; avg_mv = 32'hc1c;
    step(2);
    `CHK(empty, 1'b1)
    e_avg = 32'h0; step(2);
    `CHK(empty, 1'b0)
    `CHK(pct, 32'sd5)
    min_mv = 32'hce4; avg_mv = 32'hce4;
    $display("test empty done");
  endtask : t_empty
  // one full case: raw percent 100 reads 100 only when full holds
  task automatic full_case(input logic signed [31:0] c, input logic exp);
    cur = c; step(2);
    `CHK(full, exp)
    `CHK(pct, exp ? PCT_FULL : PCT_HIGH_HOLD)
  endtask : full_case
  // window edges with a zero period, then each voltage criterion
  task automatic t_full;
    d_pct = 32'sd100; lim = -32'sd1000; taper = 32'h5; period = 32'h0;
    f_max = 32'he10; max_mv = 32'he10;
    full_case(-32'sd1000, 1'b1);
    full_case(-32'sd1001, 1'b0);
    full_case(-32'sd5, 1'b1);
    full_case(-32'sd4, 1'b0);
    full_case(32'sd5, 1'b0);
    full_case(32'sd0, 1'b0);
    max_mv = 32'he0f;
    full_case(-32'sd500, 1'b0);
    f_max = 32'h0; max_mv = 32'he10; f_avg = 32'hd48; avg_mv = 32'hd48;
    full_case(-32'sd500, 1'b1);
    f_avg = 32'h0;
    full_case(-32'sd500, 1'b0);
    $display("test full done");
  endtask : t_full
  // qualification of 2 us needs 80 cycles in window, exit restarts it
  task automatic t_qual;
    cur = 32'sh0; f_max = 32'he10; period = 32'h2; step(2);
    cur = -32'sd500; step(60);
    `CHK(full, 1'b0)
    cur = 32'sd10; step(1);
    cur = -32'sd500; step(60);
    `CHK(full, 1'b0)
    k = 60;
    while (full !== 1'b1 && k < 120) begin
      step(1);
      k++;
    end
    if (k >= 120) begin
      n_errors++;
      wrap_up();
    end
    `CHK(k > 76 && k < 90, 1'b1)
    `CHK(pct, PCT_FULL)
    cur = 32'sd0; step(2);
    `CHK(full, 1'b0)
    $display("test qualify done");
  endtask : t_qual
  // open-circuit table: ends of range kept, out of range ignored
  task automatic t_ocv;
    wr_en = 1'b1; wr_idx = 7'h00; wr_mv = 32'haf0; step(1);
    wr_idx = 7'h64; wr_mv = 32'he42; step(1);
    wr_idx = 7'h65; wr_mv = 32'h4d2; step(1);
    wr_en = 1'b0; rd_idx = 7'h00; step(2);
    `CHK(rd_mv, 32'haf0)
    rd_idx = 7'h64; step(2);
    `CHK(rd_mv, 32'he42)
    rd_idx = 7'h65; step(2);
    `CHK(rd_mv, 32'h0)
    $display("test table done");
  endtask : t_ocv
  // capacity and cycle life settings, zero life drops cycle use
  task automatic t_cfg;
    cap = 32'h0001_86a0; life = 32'h0000_0bb8; step(2);
    `CHK(cap_o, 32'h0001_86a0)
    `CHK(cyc_o, 1'b1)
    life = 32'h0; step(2);
    `CHK(cyc_o, 1'b0)
    $display("test config done");
  endtask : t_cfg
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset for 8 cycles, then every scenario in turn
  initial begin
    step(8);
    rst = 1'b0;
    `CHK(pct, 32'sh0)
    `CHK(full, 1'b0)
    t_route();
    t_clamp();
    t_empty();
    t_full();
    t_qual();
    t_ocv();
    t_cfg();
    wrap_up();
  end
endmodule : csed_top_bench
